// *** src/ams_pkg.sv ***
// constants, offsets and state codes for the adc mode sequencer
package ams_pkg;
    // register byte offsets
    localparam logic [7:0] OFF_MODE   = 8'h00;
    localparam logic [7:0] OFF_CTRL   = 8'h04;
    localparam logic [7:0] OFF_STAT   = 8'h08;
    localparam logic [7:0] OFF_GAIN   = 8'h0C;
    localparam logic [7:0] OFF_EGAIN  = 8'h10;
    localparam logic [7:0] OFF_COFS   = 8'h20; // + 4 * channel
    localparam logic [7:0] OFF_CGAIN  = 8'h30; // + 4 * channel
    // mode register fields
    localparam int MODE_RES_BIT  = 6;
    localparam int MODE_LPREF_BIT = 5;
    localparam int MODE_PWR_LSB  = 3;
    localparam int MODE_OP_LSB   = 0;
    localparam logic [7:0] MODE_RST   = 8'h00;
    localparam logic [7:0] MODE_WMASK = 8'h7F; // top bit reads zero
    // power mode codes
    localparam logic [1:0] PWR_NORMAL = 2'h0;
    localparam logic [1:0] PWR_LOW    = 2'h1;
    localparam logic [1:0] PWR_LOWP   = 2'h2;
    // operation mode codes
    localparam logic [2:0] OP_DOWN  = 3'h0;
    localparam logic [2:0] OP_CONT  = 3'h1;
    localparam logic [2:0] OP_SINGLE = 3'h2;
    localparam logic [2:0] OP_IDLE  = 3'h3;
    localparam logic [2:0] OP_OCAL  = 3'h4;
    localparam logic [2:0] OP_GCAL  = 3'h5;
    localparam logic [2:0] OP_ZCAL  = 3'h6;
    localparam logic [2:0] OP_FCAL  = 3'h7;
    // gain codes
    localparam logic [3:0] GAIN_128 = 4'h7;
    localparam logic [3:0] GAIN_512 = 4'h9;
    localparam logic [3:0] GAIN_RST = 4'h0;
    // control register: channel enables low, chop enable above
    localparam int CTRL_CHOP_BIT = 3;
    localparam logic [3:0] CTRL_RST = 4'h0;
    // status register: conversion ready per channel, calibration ready above
    localparam int STAT_CAL_BIT = 3;
    // converter clock cycles per conversion step
    localparam logic [1:0] TICKS_NOCHOP = 2'h2;
    localparam logic [1:0] TICKS_CHOP   = 2'h3;
    localparam logic [1:0] TICKS_SYSCAL = 2'h3;
    // calibration input source
    localparam logic [1:0] SRC_INPUT = 2'h0;
    localparam logic [1:0] SRC_ZERO  = 2'h1;
    localparam logic [1:0] SRC_REF   = 2'h2;
    localparam logic [1:0] SRC_PINS  = 2'h3;
    typedef enum logic [8:0] {
        ST_DOWN   = 9'b0_0000_0001,
        ST_CONT   = 9'b0_0000_0010,
        ST_SINGLE = 9'b0_0000_0100,
        ST_IDLE   = 9'b0_0000_1000,
        ST_OCAL   = 9'b0_0001_0000,
        ST_GCAL1  = 9'b0_0010_0000,
        ST_GCAL2  = 9'b0_0100_0000,
        ST_ZCAL   = 9'b0_1000_0000,
        ST_FCAL   = 9'b1_0000_0000
    } ams_state_e;
endpackage

// *** src/ams_tick_counter.sv ***
// counts converter clock ticks and pulses when a step completes
`timescale 1ns/100ps
module ams_tick_counter
(
    input  wire logic       clk,
    input  wire logic       resetn,
    input  wire logic       clear,
    input  wire logic       run,
    input  wire logic       tick,
    input  wire logic [1:0] target,
    output logic            done
);
    logic [1:0] count_q;

    // step ends on the tick that completes the target count
    assign done = run && !clear && tick && (count_q == target - 2'd1);

    // count ticks, restart on clear, completion or stop
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            count_q <= 2'd0;
        else if (clear || done || !run)
            count_q <= 2'd0;
        else if (tick)
            count_q <= count_q + 2'd1;
    end

    // a completed step restarts the count, so the next step is full length
    property p_step_len;
        @(posedge clk) disable iff (!resetn)
        done |=> (count_q == 2'd0);
    endproperty
    a_step_len: assert property (p_step_len) else $error("step ended early");
endmodule

// *** src/ams_mode_sequencer.sv ***
// adc subsystem mode sequencer with avalon-mm register slave
//
// Functional notes
// - power mode 00 runs normally using the programmed gain.
// - power mode 01 forces gain 128 and selects the 131 kHz oscillator.
// - power mode 10 forces gain 512 whatever gain is programmed.
// - operation code 000 powers down all converters and the reference.
// - code 001 makes enabled converters convert back to back forever.
// - code 010 makes enabled converters convert exactly once.
// - after the single conversion the subsystem drops to idle itself.
// - one conversion lasts two ticks, three when chopping is on.
// - code 011 keeps converters powered but held in reset.
// - code 100 calibrates offset against an internal zero input.
// - offset calibration result goes to the channel offset coefficient.
// - offset calibration end sets calibration and conversion ready, goes idle.
// - code 101 calibrates gain against the internal reference.
// - gain calibration has two stages, twice the offset duration.
// - gain calibration result goes to the channel gain coefficient.
// - gain calibration end sets calibration and conversion ready, goes idle.
// - code 110 calibrates zero scale against external pin voltage.
// - system zero scale calibration takes three converter cycles.
// - code 111 calibrates full scale against external pin input.
//
// Design decisions made here: the Avalon-MM register port and the address map.
`timescale 1ns/100ps
module ams_mode_sequencer
#(
    parameter int CH = 3,
    parameter int CW = 24
)
(
    input  wire logic            clk,
    input  wire logic            resetn,
    input  wire logic [7:0]      avs_address,
    input  wire logic            avs_read,
    input  wire logic            avs_write,
    input  wire logic [31:0]     avs_writedata,
    input  wire logic [3:0]      avs_byteenable,
    output logic [31:0]          avs_readdata,
    output logic                 avs_waitrequest,
    input  wire logic            conv_tick,
    input  wire logic [CH*CW-1:0] conv_result,
    output logic                 adc_power_on,
    output logic                 ref_power_on,
    output logic                 conv_hold_reset,
    output logic                 lp_osc_sel,
    output logic                 lp_ref_precise,
    output logic                 res_20k_sel,
    output logic [3:0]           eff_gain_code,
    output logic [CH-1:0]        chan_run,
    output logic [1:0]           cal_source
);
    import ams_pkg::*;

    ams_state_e        state_q;
    logic [7:0]        mode_q;
    logic [3:0]        ctrl_q;
    logic [3:0]        gain_q;
    logic [3:0]        stat_q;
    logic [CW-1:0]     cofs_q [CH];
    logic [CW-1:0]     cgain_q [CH];
    logic              ack_q;
    logic              wr_go;
    logic              rd_go;
    logic              mode_wr;
    logic              step_done;
    logic              step_run;
    logic [1:0]        step_ticks;
    logic [1:0]        pwr;
    logic [CH-1:0]     ch_en;
    logic              chop;
    logic              cal_end;
    logic [CH-1:0]     stat_w1c;

    // merge write data into an old value under the byte enables
    function automatic logic [31:0] be_merge(input logic [31:0] old,
                                             input logic [31:0] wd,
                                             input logic [3:0]  be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
            if (be[i])
                r[i*8 +: 8] = wd[i*8 +: 8];
        return r;
    endfunction

    // map an operation code onto its sequencer state
    function automatic ams_state_e op_state(input logic [2:0] op);
        case (op)
            OP_DOWN:   op_state = ST_DOWN;
            OP_CONT:   op_state = ST_CONT;
            OP_SINGLE: op_state = ST_SINGLE;
            OP_IDLE:   op_state = ST_IDLE;
            OP_OCAL:   op_state = ST_OCAL;
            OP_GCAL:   op_state = ST_GCAL1;
            OP_ZCAL:   op_state = ST_ZCAL;
            OP_FCAL:   op_state = ST_FCAL;
            default:   op_state = ST_DOWN;
        endcase
    endfunction

    // bus handshake: every access is answered on the second cycle
    assign avs_waitrequest = !ack_q;
    assign wr_go           = avs_write && ack_q;
    assign rd_go           = avs_read && !ack_q;
    assign mode_wr         = wr_go && (avs_address == OFF_MODE);

    // acknowledge flop
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            ack_q <= 1'b0;
        else
            ack_q <= (avs_read || avs_write) && !ack_q;
    end

    // field views
    assign pwr   = mode_q[MODE_PWR_LSB +: 2];
    assign ch_en = ctrl_q[CH-1:0];
    assign chop  = ctrl_q[CTRL_CHOP_BIT];

    // gain override by power mode
    always_comb
    begin
        case (pwr)
            PWR_LOW:  eff_gain_code = GAIN_128;
            PWR_LOWP: eff_gain_code = GAIN_512;
            default:  eff_gain_code = gain_q;
        endcase
    end

    // pin controls from the mode register, power and hold from the sequencer state
    assign lp_osc_sel     = (pwr == PWR_LOW);
    assign lp_ref_precise = mode_q[MODE_LPREF_BIT];
    assign res_20k_sel    = mode_q[MODE_RES_BIT];
    assign adc_power_on   = (state_q != ST_DOWN);
    assign ref_power_on   = (state_q != ST_DOWN);
    assign conv_hold_reset = (state_q == ST_IDLE) || (state_q == ST_DOWN);

    // converters run in every active state
    assign step_run = !(state_q inside {ST_DOWN, ST_IDLE});
    assign chan_run = step_run ? ch_en : '0;

    // input source per calibration kind
    always_comb
    begin
        case (state_q)
            ST_OCAL:  cal_source = SRC_ZERO;
            ST_GCAL1: cal_source = SRC_REF;
            ST_GCAL2: cal_source = SRC_REF;
            ST_ZCAL:  cal_source = SRC_PINS;
            ST_FCAL:  cal_source = SRC_PINS;
            default:  cal_source = SRC_INPUT;
        endcase
    end

    // ticks per step: system calibrations fixed, others depend on chop
    assign step_ticks = (state_q inside {ST_ZCAL, ST_FCAL}) ? TICKS_SYSCAL
                      : (chop ? TICKS_CHOP : TICKS_NOCHOP);

    ams_tick_counter u_ticks
    (
        .clk    (clk),
        .resetn (resetn),
        .clear  (mode_wr),
        .run    (step_run),
        .tick   (conv_tick),
        .target (step_ticks),
        .done   (step_done)
    );

    // calibration finishes at the end of its last step
    assign cal_end = step_done &&
                     (state_q inside {ST_OCAL, ST_GCAL2, ST_ZCAL, ST_FCAL});

    // sequencer: software write starts a mode, completion moves on
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            state_q <= ST_DOWN;
        else if (mode_wr)
            state_q <= op_state(3'(be_merge({24'h0, mode_q}, avs_writedata,
                                            avs_byteenable)));
        else if (step_done)
        begin
            case (state_q)
                ST_CONT:   state_q <= ST_CONT;
                ST_SINGLE: state_q <= ST_IDLE;
                ST_GCAL1:  state_q <= ST_GCAL2;
                ST_OCAL:   state_q <= ST_IDLE;
                ST_GCAL2:  state_q <= ST_IDLE;
                ST_ZCAL:   state_q <= ST_IDLE;
                ST_FCAL:   state_q <= ST_IDLE;
                default:   state_q <= state_q;
            endcase
        end
    end

    // mode register; a new software command outranks a completion
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            mode_q <= MODE_RST;
        else if (mode_wr)
            mode_q <= 8'(be_merge({24'h0, mode_q}, avs_writedata, avs_byteenable))
                      & MODE_WMASK;
        else if (step_done && (state_q inside {ST_SINGLE, ST_OCAL, ST_GCAL2,
                                               ST_ZCAL, ST_FCAL}))
            mode_q[MODE_OP_LSB +: 3] <= OP_IDLE;
    end

    // control and programmed gain registers
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            ctrl_q <= CTRL_RST;
            gain_q <= GAIN_RST;
        end
        else if (wr_go && avs_byteenable[0])
        begin
            if (avs_address == OFF_CTRL)
                ctrl_q <= avs_writedata[3:0];
            if (avs_address == OFF_GAIN)
                gain_q <= avs_writedata[3:0];
        end
    end

    // status: write one to clear, a new event wins over the clear
    assign stat_w1c = (wr_go && avs_address == OFF_STAT && avs_byteenable[0])
                      ? avs_writedata[CH-1:0] : '0;

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            stat_q <= 4'h0;
        else
        begin
            for (int c = 0; c < CH; c++)
                stat_q[c] <= (step_done && ch_en[c]) ||
                             (stat_q[c] && !stat_w1c[c]);
            stat_q[STAT_CAL_BIT] <= cal_end ||
                (stat_q[STAT_CAL_BIT] && !(wr_go && avs_address == OFF_STAT
                 && avs_byteenable[0] && avs_writedata[STAT_CAL_BIT]));
        end
    end

    // coefficient registers: software access, calibration results land here
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            for (int c = 0; c < CH; c++)
            begin
                cofs_q[c]  <= '0;
                cgain_q[c] <= '0;
            end
        end
        else
        begin
            for (int c = 0; c < CH; c++)
            begin
                if (wr_go && avs_address == OFF_COFS + 8'(4 * c))
                    cofs_q[c] <= CW'(be_merge(32'(cofs_q[c]), avs_writedata,
                                              avs_byteenable));
                else if (step_done && ch_en[c] &&
                         (state_q inside {ST_OCAL, ST_ZCAL}))
                    cofs_q[c] <= conv_result[c*CW +: CW];
                if (wr_go && avs_address == OFF_CGAIN + 8'(4 * c))
                    cgain_q[c] <= CW'(be_merge(32'(cgain_q[c]), avs_writedata,
                                               avs_byteenable));
                else if (step_done && ch_en[c] &&
                         (state_q inside {ST_GCAL2, ST_FCAL}))
                    cgain_q[c] <= conv_result[c*CW +: CW];
            end
        end
    end

    // read data registered in the request cycle, unmapped reads zero
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            avs_readdata <= 32'h0000_0000;
        else if (rd_go)
        begin
            avs_readdata <= 32'h0000_0000;
            case (avs_address)
                OFF_MODE:  avs_readdata <= {24'h00_0000, mode_q};
                OFF_CTRL:  avs_readdata <= {28'h000_0000, ctrl_q};
                OFF_STAT:  avs_readdata <= {28'h000_0000, stat_q};
                OFF_GAIN:  avs_readdata <= {28'h000_0000, gain_q};
                OFF_EGAIN: avs_readdata <= {28'h000_0000, eff_gain_code};
                default:
                begin
                    for (int c = 0; c < CH; c++)
                    begin
                        if (avs_address == OFF_COFS + 8'(4 * c))
                            avs_readdata <= 32'(cofs_q[c]);
                        if (avs_address == OFF_CGAIN + 8'(4 * c))
                            avs_readdata <= 32'(cgain_q[c]);
                    end
                end
            endcase
        end
    end

    // checks
    property p_lp_gain;
        @(posedge clk) disable iff (!resetn)
        (pwr == PWR_LOW) |-> (eff_gain_code == GAIN_128) && lp_osc_sel;
    endproperty
    a_lp_gain: assert property (p_lp_gain) else $error("low power gain");
    property p_lpp_gain;
        @(posedge clk) disable iff (!resetn)
        (pwr == PWR_LOWP) |-> (eff_gain_code == GAIN_512) && !lp_osc_sel;
    endproperty
    a_lpp_gain: assert property (p_lpp_gain) else $error("low power plus gain");
    property p_norm_gain;
        @(posedge clk) disable iff (!resetn)
        (pwr == PWR_NORMAL) |-> (eff_gain_code == gain_q);
    endproperty
    a_norm_gain: assert property (p_norm_gain) else $error("normal gain");
    property p_down_off;
        @(posedge clk) disable iff (!resetn)
        (mode_q[2:0] == OP_DOWN) |-> !adc_power_on && !ref_power_on && chan_run == '0;
    endproperty
    a_down_off: assert property (p_down_off) else $error("power down");
    property p_idle_hold;
        @(posedge clk) disable iff (!resetn)
        (state_q == ST_IDLE) |-> adc_power_on && conv_hold_reset && !step_done;
    endproperty
    a_idle_hold: assert property (p_idle_hold) else $error("idle hold");
    sequence s_single_end;
        (state_q == ST_SINGLE) && step_done && !mode_wr;
    endsequence
    property p_single_idle;
        @(posedge clk) disable iff (!resetn)
        s_single_end |=> (state_q == ST_IDLE) && (mode_q[2:0] == OP_IDLE);
    endproperty
    a_single_idle: assert property (p_single_idle) else $error("single end");
    sequence s_cal_end;
        cal_end && !mode_wr && !(wr_go && avs_address == OFF_STAT);
    endsequence
    property p_cal_flags;
        @(posedge clk) disable iff (!resetn)
        s_cal_end |=> stat_q[STAT_CAL_BIT] && (mode_q[2:0] == OP_IDLE);
    endproperty
    a_cal_flags: assert property (p_cal_flags) else $error("cal flags");
    property p_ocal_coef;
        @(posedge clk) disable iff (!resetn)
        (state_q == ST_OCAL) && step_done && ch_en[0] && !wr_go
        |=> cofs_q[0] == $past(conv_result[CW-1:0]);
    endproperty
    a_ocal_coef: assert property (p_ocal_coef) else $error("offset coef");
    property p_gcal_stages;
        @(posedge clk) disable iff (!resetn)
        (state_q == ST_GCAL1) && step_done && !mode_wr |=> (state_q == ST_GCAL2);
    endproperty
    a_gcal_stages: assert property (p_gcal_stages) else $error("gain stages");
    property p_cont_stays;
        @(posedge clk) disable iff (!resetn)
        (state_q == ST_CONT) && step_done && !mode_wr |=> (state_q == ST_CONT);
    endproperty
    a_cont_stays: assert property (p_cont_stays) else $error("continuous");
endmodule

// *** verif/tb_ams_mode_sequencer.sv ***
// self-checking bench for the adc mode sequencer
`timescale 1ns/100ps
module tb_ams_mode_sequencer;
    import ams_pkg::*;
    localparam int CH = 3;
    localparam int CW = 24;
    logic            clk;
    logic            resetn;
    logic [7:0]      avs_address;
    logic            avs_read;
    logic            avs_write;
    logic [31:0]     avs_writedata;
    logic [3:0]      avs_byteenable;
    logic [31:0]     avs_readdata;
    logic            avs_waitrequest;
    logic            conv_tick;
    logic [CH*CW-1:0] conv_result;
    logic            adc_power_on;
    logic            ref_power_on;
    logic            conv_hold_reset;
    logic            lp_osc_sel;
    logic            lp_ref_precise;
    logic            res_20k_sel;
    logic [3:0]      eff_gain_code;
    logic [CH-1:0]   chan_run;
    logic [1:0]      cal_source;
    int              fails;
    int              check_count;
    logic [31:0]     rd;

    ams_mode_sequencer #(.CH(CH), .CW(CW)) i_dut (
        .clk(clk), .resetn(resetn), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .conv_tick(conv_tick),
        .conv_result(conv_result), .adc_power_on(adc_power_on),
        .ref_power_on(ref_power_on), .conv_hold_reset(conv_hold_reset),
        .lp_osc_sel(lp_osc_sel), .lp_ref_precise(lp_ref_precise),
        .res_20k_sel(res_20k_sel), .eff_gain_code(eff_gain_code),
        .chan_run(chan_run), .cal_source(cal_source));

    // 125 mhz clock
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // compare one value and count it
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            fails++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // print the counts and the verdict, then stop
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // one avalon transfer: hold the request until waitrequest is sampled low
    task automatic bus_xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        avs_address    <= a;
        avs_writedata  <= d;
        avs_byteenable <= 4'hF;
        avs_write      <= wr;
        avs_read       <= ~wr;
        // wait for the answer; only the watchdog ends a hung transfer
        do
        begin
            @(posedge clk);
        end
        while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
        // let the answer edge's updates settle before outputs are looked at
        @(negedge clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus_xfer(1'b1, a, d);
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        bus_xfer(1'b0, a, 32'h0000_0000);
        check(rd, exp);
    endtask

    // converter clock pulses, one cycle wide with a gap
    task automatic tick(input int n);
        repeat (n)
        begin
            @(posedge clk);
            conv_tick <= 1'b1;
            @(posedge clk);
            conv_tick <= 1'b0;
        end
        @(posedge clk);
    endtask

    // reset state, bit 7 and unmapped places
    task automatic t_reset;
        check(32'(adc_power_on), 32'h0000_0000);
        check(32'(conv_hold_reset), 32'h0000_0001);
        rdchk(OFF_MODE, 32'h0000_0000);
        wr(8'hFC, 32'hFFFF_FFFF);
        rdchk(8'hFC, 32'h0000_0000);
        wr(OFF_MODE, 32'h0000_00E3);
        rdchk(OFF_MODE, 32'h0000_0063);
        check(32'(res_20k_sel), 32'h0000_0001);
        check(32'(lp_ref_precise), 32'h0000_0001);
    endtask

    // power mode gain override, idle holds powered converters in reset
    task automatic t_power;
        logic [3:0] g;
        wr(OFF_GAIN, 32'h0000_0003);
        wr(OFF_CTRL, 32'h0000_0007);
        for (int p = 0; p < 3; p++)
        begin
            g = (p == 1) ? GAIN_128 : (p == 2) ? GAIN_512 : 4'h3;
            wr(OFF_MODE, 32'((p << MODE_PWR_LSB) | OP_IDLE));
            check(32'(eff_gain_code), 32'(g));
            rdchk(OFF_EGAIN, 32'(g));
            check(32'(lp_osc_sel), 32'(p == 1));
            check(32'(adc_power_on), 32'h0000_0001);
            check(32'(ref_power_on), 32'h0000_0001);
            check(32'(conv_hold_reset), 32'h0000_0001);
            check(32'(chan_run), 32'h0000_0000);
        end
    endtask

    // power-down switches all off and ignores ticks
    task automatic t_down;
        wr(OFF_STAT, 32'h0000_000F);
        wr(OFF_MODE, 32'(OP_DOWN));
        check(32'(adc_power_on), 32'h0000_0000);
        check(32'(ref_power_on), 32'h0000_0000);
        tick(3);
        rdchk(OFF_STAT, 32'h0000_0000);
        rdchk(OFF_MODE, 32'h0000_0000);
    endtask

    // single conversion: exact tick count, then idle by itself
    task automatic t_single(input logic chop);
        int n;
        n = chop ? 3 : 2;
        wr(OFF_STAT, 32'h0000_000F);
        wr(OFF_CTRL, 32'h0000_0005 | (32'(chop) << CTRL_CHOP_BIT));
        wr(OFF_MODE, 32'(OP_SINGLE));
        check(32'(chan_run), 32'h0000_0005);
        check(32'(conv_hold_reset), 32'h0000_0000);
        tick(n - 1);
        rdchk(OFF_STAT, 32'h0000_0000);
        rdchk(OFF_MODE, 32'(OP_SINGLE));
        tick(1);
        rdchk(OFF_STAT, 32'h0000_0005);
        rdchk(OFF_MODE, 32'(OP_IDLE));
        check(32'(chan_run), 32'h0000_0000);
        check(32'(conv_hold_reset), 32'h0000_0001);
    endtask

    // continuous mode keeps converting without software
    task automatic t_cont;
        wr(OFF_STAT, 32'h0000_000F);
        wr(OFF_CTRL, 32'h0000_0003);
        wr(OFF_MODE, 32'(OP_CONT));
        tick(2);
        rdchk(OFF_STAT, 32'h0000_0003);
        wr(OFF_STAT, 32'h0000_000F);
        tick(2);
        rdchk(OFF_STAT, 32'h0000_0003);
        rdchk(OFF_MODE, 32'(OP_CONT));
        check(32'(chan_run), 32'h0000_0003);
    endtask

    // calibration: source, length, coefficient write, flags, return to idle
    task automatic t_cal(input logic [2:0] op, input int n, input logic [1:0] src,
                         input logic [7:0] base, input logic [2:0] en);
        logic [23:0] r0;
        logic [23:0] r1;
        logic [23:0] r2;
        r0 = 24'h10_0000 + 24'(op);
        r1 = 24'h20_0000 + 24'(op);
        r2 = 24'h30_0000 + 24'(op);
        wr(OFF_STAT, 32'h0000_000F);
        @(posedge clk);
        conv_result <= {r2, r1, r0};
        wr(OFF_CTRL, 32'(en));
        wr(OFF_MODE, 32'(op));
        check(32'(cal_source), 32'(src));
        check(32'(chan_run), 32'(en));
        tick(n - 1);
        bus_xfer(1'b0, OFF_STAT, 32'h0000_0000);
        check(rd & 32'h0000_0008, 32'h0000_0000);
        rdchk(OFF_MODE, 32'(op));
        tick(1);
        rdchk(OFF_STAT, 32'h0000_0008 | 32'(en));
        rdchk(OFF_MODE, 32'(OP_IDLE));
        rdchk(base, en[0] ? 32'(r0) : 32'h0000_0000);
        rdchk(base + 8'h04, en[1] ? 32'(r1) : 32'h0000_0000);
        rdchk(base + 8'h08, en[2] ? 32'(r2) : 32'h0000_0000);
    endtask

    // watchdog
    initial
    begin
        #100000;
        fails++;
        wrap_up();
    end

    // main sequence
    initial
    begin
        fails = 0;
        check_count = 0;
        resetn = 1'b0;
        avs_address = 8'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0000_0000;
        avs_byteenable = 4'h0;
        conv_tick = 1'b0;
        conv_result = '0;
        repeat (12) @(posedge clk);
        resetn <= 1'b1;
        t_reset();
        t_power();
        t_down();
        t_single(1'b0);
        t_single(1'b1);
        t_cont();
        t_cal(OP_OCAL, 2, SRC_ZERO, OFF_COFS, 3'h7);
        t_cal(OP_GCAL, 4, SRC_REF, OFF_CGAIN, 3'h1);
        t_cal(OP_ZCAL, 3, SRC_PINS, OFF_COFS, 3'h7);
        t_cal(OP_FCAL, 3, SRC_PINS, OFF_CGAIN, 3'h7);
        wrap_up();
    end
endmodule
